// [rtl/wdg_top.sv]
// Watchdog timer with reset-cause flags, reached over APB
`default_nettype none
`include "wdg_defines.svh"

module wdg_top #(
    parameter int unsigned BASE_TICKS = `WDG_BASE_TICKS
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire wdg_pkg::wdg_apb_req_t apb_req,
    output var  wdg_pkg::wdg_apb_rsp_t apb_rsp,
    input  wire logic                  por_event,
    input  wire logic                  bor_event,
    input  wire logic                  ext_event,
    input  wire logic                  wdr_instr,
    input  wire logic                  wdt_osc_clk,
    input  wire logic                  safety_level_fuse,
    input  wire logic                  global_int_enable,
    input  wire logic                  wdt_vector_taken,
    output logic                       wdt_irq,
    output logic                       wdt_reset_pulse
);
    import wdg_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] cause;
        logic       timeout_interrupt_flag;
        logic       timeout_interrupt_enable;
        logic       ie_drop;
        logic       watchdog_enable_bit;
        logic       ce;
        logic [2:0] ce_cnt;
        logic [3:0] psel;
        logic       rst_pulse;
        logic       irq;
        logic [7:0] rdata;
    } wdg_top_st_t;

    wdg_top_st_t st_ff;
    wdg_top_st_t nxt_st;

    logic       osc_tick;
    logic       timeout;
    logic       restart;
    logic       wde_eff;
    logic       running;
    logic       setup_rd;
    logic       access;
    logic       hit_ctl;
    logic       hit_cause;
    logic       wr_ctl;
    logic       wr_cause;
    logic       ce_wr;
    logic [7:0] wdata;
    logic [7:0] ctl_view;
    logic [7:0] cause_view;

    // ----------------------------------------------------------------
    // Oscillator crossing and time-out counter
    // ----------------------------------------------------------------
    // The slow oscillator is sampled as a level; 128 kHz against a
    // 40 MHz clock leaves ample margin for the two-flop chain.
    wdg_sync u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in (wdt_osc_clk),
        .tick     (osc_tick)
    );

    wdg_presc #(
        .BASE_TICKS (BASE_TICKS)
    ) u_presc (
        .clk        (clk),
        .reset_n    (reset_n),
        .tick       (osc_tick),
        .restart    (restart),
        .sel        (st_ff.psel),
        .timeout    (timeout)
    );

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    // Level 2 pins enable high; level 1 lets the watchdog-reset flag
    // hold it high until software clears that flag first.
    assign wde_eff = safety_level_fuse
                   | st_ff.watchdog_enable_bit
                   | st_ff.cause[`WDG_CAUSE_WD];
    assign running = wde_eff | st_ff.timeout_interrupt_enable;
    assign restart = wdr_instr | ~running | timeout;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    assign hit_ctl   = apb_req.paddr == {`WDG_IDX_CTL, 2'b00};
    assign hit_cause = apb_req.paddr == {`WDG_IDX_CAUSE, 2'b00};
    assign access    = apb_req.psel & apb_req.penable;
    assign setup_rd  = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    assign wr_ctl    = access & apb_req.pwrite & hit_ctl;
    assign wr_cause  = access & apb_req.pwrite & hit_cause;
    assign wdata     = apb_req.pwdata[7:0];
    assign ce_wr     = wr_ctl & wdata[`WDG_CTL_CE];

    assign ctl_view   = {st_ff.timeout_interrupt_flag, st_ff.timeout_interrupt_enable, st_ff.psel[3], st_ff.ce,
                         wde_eff, st_ff.psel[2:0]};
    assign cause_view = {4'h0, st_ff.cause};

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.rst_pulse = 1'b0;
        nxt_st.ie_drop   = 1'b0;

        // Read data captured in the setup phase, zero wait states
        if (setup_rd) begin
            if (hit_ctl) begin
                nxt_st.rdata = ctl_view;
            end else if (hit_cause) begin
                nxt_st.rdata = cause_view;
            end else begin
                nxt_st.rdata = 8'h00;
            end
        end

        // Change-enable window
        if (st_ff.ce) begin
            if (st_ff.ce_cnt == `WDG_CE_WINDOW - 3'd1) begin
                nxt_st.ce     = 1'b0;
                nxt_st.ce_cnt = 3'd0;
            end else begin
                nxt_st.ce_cnt = st_ff.ce_cnt + 3'd1;
            end
        end
        if (ce_wr) begin
            nxt_st.ce     = 1'b1;
            nxt_st.ce_cnt = 3'd0;
        end

        // Control writes
        if (wr_ctl) begin
            nxt_st.timeout_interrupt_enable = wdata[`WDG_CTL_IE];
            if (wdata[`WDG_CTL_EN]) begin
                nxt_st.watchdog_enable_bit = 1'b1;
            end else if (st_ff.ce) begin
                nxt_st.watchdog_enable_bit = 1'b0;
            end
            // Level 1 changes the period freely, level 2 needs the window
            if (!safety_level_fuse || st_ff.ce) begin
                nxt_st.psel = {wdata[`WDG_CTL_P3], wdata[2:0]};
            end
            if (wdata[`WDG_CTL_IF]) begin
                nxt_st.timeout_interrupt_flag = 1'b0;
            end
        end
        // Late drop lets the combined mode still raise its request
        if (st_ff.ie_drop) begin
            nxt_st.timeout_interrupt_enable = 1'b0;
        end
        if (wdt_vector_taken) begin
            nxt_st.timeout_interrupt_flag = 1'b0;
        end

        // Cause register: a written zero clears, a one leaves alone
        if (wr_cause) begin
            nxt_st.cause = st_ff.cause & wdata[3:0];
        end
        if (por_event) begin
            nxt_st.cause = 4'h0;
            nxt_st.cause[`WDG_CAUSE_PO] = 1'b1;
        end

        // Time-out action; sets come last so they win over clears
        if (timeout && running) begin
            if (st_ff.timeout_interrupt_enable) begin
                nxt_st.timeout_interrupt_flag = 1'b1;
                if (wde_eff) begin
                    nxt_st.ie_drop = 1'b1;
                end
            end else begin
                nxt_st.rst_pulse = 1'b1;
                nxt_st.cause[`WDG_CAUSE_WD] = 1'b1;
            end
        end
        if (bor_event) begin
            nxt_st.cause[`WDG_CAUSE_BO] = 1'b1;
        end
        if (ext_event) begin
            nxt_st.cause[`WDG_CAUSE_EX] = 1'b1;
        end

        nxt_st.irq = st_ff.timeout_interrupt_flag & st_ff.timeout_interrupt_enable
                   & global_int_enable;

        // Chip reset clears control but keeps the cause flags
        if (!reset_n) begin
            nxt_st.timeout_interrupt_flag      = 1'b0;
            nxt_st.timeout_interrupt_enable      = 1'b0;
            nxt_st.ie_drop   = 1'b0;
            nxt_st.watchdog_enable_bit       = 1'b0;
            nxt_st.ce        = 1'b0;
            nxt_st.ce_cnt    = 3'd0;
            nxt_st.psel      = `WDG_PSEL_RST;
            nxt_st.rst_pulse = 1'b0;
            nxt_st.irq       = 1'b0;
            nxt_st.rdata     = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign apb_rsp.prdata  = {24'h0, st_ff.rdata};
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = access & ~hit_ctl & ~hit_cause;
    assign wdt_irq         = st_ff.irq;
    assign wdt_reset_pulse = st_ff.rst_pulse;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking

    default disable iff (!reset_n);

    sequence s_ce_open;
        $rose(st_ff.ce);
    endsequence

    sequence s_ce_quiet;
        (st_ff.ce && !ce_wr) [*3];
    endsequence

    sequence s_ce_close;
        st_ff.ce ##1 (!st_ff.ce || $past(ce_wr));
    endsequence

    a_rsv_zero: assert property (
        setup_rd && hit_cause |=> st_ff.rdata[7:4] == 4'h0
    ) else $error("reserved cause bits read non-zero");

    a_watchdog_reset_cause_flag_set: assert property (
        wdt_reset_pulse |-> st_ff.cause[`WDG_CAUSE_WD]
    ) else $error("watchdog reset without its cause flag");

    a_brownout_cause_flag_set: assert property (
        bor_event |=> st_ff.cause[`WDG_CAUSE_BO]
    ) else $error("brown-out cause flag not set");

    a_external_pin_cause_flag_set: assert property (
        ext_event |=> st_ff.cause[`WDG_CAUSE_EX]
    ) else $error("external cause flag not set");

    a_power_on_cause_flag_only: assert property (
        por_event && !bor_event && !ext_event && !timeout
        |=> st_ff.cause[`WDG_CAUSE_PO]
            && st_ff.cause[`WDG_CAUSE_WD:`WDG_CAUSE_EX] == 3'b000
    ) else $error("power-on did not set flag or clear the others");

    a_timeout_interrupt_flag_set: assert property (
        timeout && st_ff.timeout_interrupt_enable |=> st_ff.timeout_interrupt_flag
    ) else $error("interrupt flag missed on time-out");

    a_irq_gate: assert property (
        wdt_irq |-> $past(global_int_enable)
                    && $past(st_ff.timeout_interrupt_flag) && $past(st_ff.timeout_interrupt_enable)
    ) else $error("interrupt without flag, enable and global enable");

    a_ie_clear: assert property (
        timeout && st_ff.timeout_interrupt_enable && wde_eff |=> ##1 !st_ff.timeout_interrupt_enable
    ) else $error("interrupt enable kept after time-out");

    a_ce_window: assert property (
        s_ce_open ##0 s_ce_quiet |=> s_ce_close
    ) else $error("change enable window not four cycles");

    a_en_guard: assert property (
        $fell(st_ff.watchdog_enable_bit) |-> $past(st_ff.ce)
    ) else $error("enable cleared outside change window");

    a_psel_guard: assert property (
        safety_level_fuse && $changed(st_ff.psel)
        |-> $past(st_ff.ce)
    ) else $error("prescaler changed outside window in level 2");

    a_lvl2_on: assert property (
        safety_level_fuse |-> wde_eff && ctl_view[`WDG_CTL_EN]
    ) else $error("level 2 watchdog not enabled");

    a_lvl1_force: assert property (
        st_ff.cause[`WDG_CAUSE_WD] |-> wde_eff
    ) else $error("enable not forced by watchdog reset flag");

    a_stop_idle: assert property (
        !running ##1 !running |-> !timeout
    ) else $error("time-out while watchdog stopped");

    a_rst_width: assert property (
        wdt_reset_pulse |=> !wdt_reset_pulse
    ) else $error("reset pulse longer than one cycle");

    a_rst_cause: assert property (
        timeout && running && !st_ff.timeout_interrupt_enable |=> wdt_reset_pulse
    ) else $error("reset mode time-out gave no pulse");

endmodule

`default_nettype wire

// [inc/wdg_defines.svh]
// Offsets, field positions, reset values and counts of the watchdog block
`ifndef WDG_DEFINES_SVH
`define WDG_DEFINES_SVH

// ----------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------
`define WDG_ADDR_W        10
`define WDG_DATA_W        32

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define WDG_IDX_CAUSE     8'h20
`define WDG_IDX_CTL       8'h21

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WDG_CTL_IF        7
`define WDG_CTL_IE        6
`define WDG_CTL_P3        5
`define WDG_CTL_CE        4
`define WDG_CTL_EN        3
`define WDG_CAUSE_WD      3
`define WDG_CAUSE_BO      2
`define WDG_CAUSE_EX      1
`define WDG_CAUSE_PO      0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define WDG_PSEL_RST      4'h0
`define WDG_PSEL_MAX      4'h9
`define WDG_CE_WINDOW     3'd4
`define WDG_BASE_TICKS    2048
`define WDG_CNT_W         21

`endif

// [inc/wdg_pkg.sv]
// Types shared by the watchdog block and its bus
`default_nettype none
`include "wdg_defines.svh"

package wdg_pkg;

    typedef struct packed {
        logic                   psel;
        logic                   penable;
        logic                   pwrite;
        logic [`WDG_ADDR_W-1:0] paddr;
        logic [`WDG_DATA_W-1:0] pwdata;
    } wdg_apb_req_t;

    typedef struct packed {
        logic [`WDG_DATA_W-1:0] prdata;
        logic                   pready;
        logic                   pslverr;
    } wdg_apb_rsp_t;

endpackage

`default_nettype wire

// [rtl/wdg_sync.sv]
// Two-flop synchroniser for the slow oscillator with rising-edge tick
`default_nettype none
`include "wdg_defines.svh"

module wdg_sync (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic async_in,
    output logic      tick
);
    import wdg_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic tick;
    } wdg_sync_st_t;

    wdg_sync_st_t st_ff;
    wdg_sync_st_t nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.s1   = async_in;
        nxt_st.s2   = st_ff.s1;
        nxt_st.s3   = st_ff.s2;
        // Edge taken only past the second stage
        nxt_st.tick = st_ff.s2 & ~st_ff.s3;
        // Chain keeps shifting in reset so no false edge follows it
        if (!reset_n) begin
            nxt_st.tick = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    assign tick = st_ff.tick;

endmodule

`default_nettype wire

// [rtl/wdg_presc.sv]
// Time-out counter clocked by synchronised oscillator ticks
`default_nettype none
`include "wdg_defines.svh"

module wdg_presc #(
    parameter int unsigned BASE_TICKS = `WDG_BASE_TICKS
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       tick,
    input  wire logic       restart,
    input  wire logic [3:0] sel,
    output logic            timeout
);
    import wdg_pkg::*;

    typedef struct packed {
        logic [`WDG_CNT_W-1:0] cnt;
        logic                  to;
    } wdg_presc_st_t;

    wdg_presc_st_t         st_ff;
    wdg_presc_st_t         nxt_st;
    logic [3:0]            sel_eff;
    logic [`WDG_CNT_W-1:0] limit;

    // Reserved codes behave as the longest period
    assign sel_eff = (sel > `WDG_PSEL_MAX) ? `WDG_PSEL_MAX : sel;
    assign limit   = `WDG_CNT_W'(BASE_TICKS) << sel_eff;

    always_comb begin
        nxt_st    = st_ff;
        nxt_st.to = 1'b0;
        if (restart) begin
            nxt_st.cnt = '0;
        end else if (tick) begin
            if (st_ff.cnt == limit - 1'b1) begin
                nxt_st.cnt = '0;
                nxt_st.to  = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 1'b1;
            end
        end
        if (!reset_n) begin
            nxt_st = '0;
        end
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    assign timeout = st_ff.to;

endmodule

`default_nettype wire

// [bench/watchdog_with_reset_flags_tb_top.sv]
// Self-checking bench for the watchdog with reset-cause flags
`default_nettype none
`include "wdg_defines.svh"

module watchdog_with_reset_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import wdg_pkg::*;

    // ------------------------------------------------------------
    // Stimulus signals and design
    // ------------------------------------------------------------
    typedef struct packed {
        logic [9:0] a;
        logic       w;
        logic [7:0] d;
        logic [7:0] e;
        logic       err;
    } wwrf_row_t;

    localparam int unsigned TICKS   = 4;
    localparam logic [9:0]  A_CAUSE = 10'(`WDG_IDX_CAUSE * 4);
    localparam logic [9:0]  A_CTL   = 10'(`WDG_IDX_CTL * 4);
    localparam logic [9:0]  A_NONE  = 10'h088;

    logic         clk;
    logic         reset_n;
    wdg_apb_req_t req;
    wdg_apb_rsp_t rsp;
    logic         por_ev;
    logic         bor_ev;
    logic         ext_ev;
    logic         kick;
    logic         osc;
    logic         fuse;
    logic         gie;
    logic         vec;
    logic         irq;
    logic         rst_pulse;
    logic [31:0]  rd;
    logic         err;
    int           errors;
    int           compares;
    int           pulses;
    int           n;
    int           p0;
    wwrf_row_t    rows [4] = '{
        '{A_CAUSE, 1'b1, 8'hff, 8'h01, 1'b0},
        '{A_CAUSE, 1'b1, 8'h00, 8'h00, 1'b0},
        '{A_CTL,   1'b1, 8'h25, 8'h25, 1'b0},
        '{A_NONE,  1'b1, 8'h5a, 8'h00, 1'b1}
    };

    wdg_top #(.BASE_TICKS(TICKS)) u_dut (
        .clk               (clk),
        .reset_n           (reset_n),
        .apb_req           (req),
        .apb_rsp           (rsp),
        .por_event         (por_ev),
        .bor_event         (bor_ev),
        .ext_event         (ext_ev),
        .wdr_instr         (kick),
        .wdt_osc_clk       (osc),
        .safety_level_fuse (fuse),
        .global_int_enable (gie),
        .wdt_vector_taken  (vec),
        .wdt_irq           (irq),
        .wdt_reset_pulse   (rst_pulse)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Free-running 128 kHz oscillator, unrelated in phase to clk
    initial begin
        osc = 1'b0;
        forever #3906.25 osc = ~osc;
    end

    always @(posedge clk) begin
        if (rst_pulse === 1'b1) begin
            pulses <= pulses + 1;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    // Leaves the bus selected so a next setup may follow at once
    task automatic xfer(input logic [9:0] a, input logic w,
                        input logic [7:0] d);
        int k;
        k = 0;
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= w;
        req.paddr   <= a;
        req.pwdata  <= {24'h0, d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        if (k >= 50) errors++;
        rd  = rsp.prdata;
        err = rsp.pslverr;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rchk(input logic [9:0] a, input logic [7:0] e);
        xfer(a, 1'b0, 8'h00);
        chk(rd, {24'h0, e});
    endtask

    // Release the bus for cyc cycles; five lets the change window lapse
    task automatic idle(input int cyc);
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        repeat (cyc) @(posedge clk);
    endtask

    // Observes at the falling edge, clear of register updates
    task automatic wait_hi(input bit sel_rst, input int lim);
        n = 0;
        while ((sel_rst ? rst_pulse : irq) !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) errors++;
    endtask

    task automatic end_sim();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        errors = 0;
        compares = 0;
        pulses = 0;
        reset_n = 1'b0;
        req = '0;
        por_ev = 1'b1;
        bor_ev = 1'b0;
        ext_ev = 1'b0;
        kick = 1'b0;
        fuse = 1'b0;
        gie = 1'b0;
        vec = 1'b0;
        @(posedge clk);
        por_ev <= 1'b0;
        repeat (11) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rchk(A_CAUSE, 8'h01);
        rchk(A_CTL, 8'h00);
        foreach (rows[i]) begin
            xfer(rows[i].a, 1'b1, rows[i].d);
            chk({31'h0, err}, {31'h0, rows[i].err});
            xfer(rows[i].a, 1'b0, 8'h00);
            chk(rd, {24'h0, rows[i].e});
            chk({31'h0, err}, {31'h0, rows[i].err});
        end
        for (int i = 0; i < 2; i++) begin
            idle(1);
            if (i == 0) bor_ev <= 1'b1;
            else ext_ev <= 1'b1;
            @(posedge clk);
            bor_ev <= 1'b0;
            ext_ev <= 1'b0;
            @(posedge clk);
            rchk(A_CAUSE, (i == 0) ? 8'h04 : 8'h06);
        end
        wr(A_CAUSE, 8'h04);
        rchk(A_CAUSE, 8'h04);
        idle(1);
        por_ev <= 1'b1;
        @(posedge clk);
        por_ev <= 1'b0;
        @(posedge clk);
        rchk(A_CAUSE, 8'h01);
        wr(A_CAUSE, 8'h00);
        wr(A_CTL, 8'h08);
        rchk(A_CTL, 8'h08);
        wr(A_CTL, 8'h00);
        rchk(A_CTL, 8'h08);
        wr(A_CTL, 8'h18);
        rchk(A_CTL, 8'h18);
        rchk(A_CTL, 8'h18);
        rchk(A_CTL, 8'h08);
        wr(A_CTL, 8'h18);
        wr(A_CTL, 8'h00);
        idle(5);
        rchk(A_CTL, 8'h00);
        gie <= 1'b1;
        wr(A_CTL, 8'h40);
        idle(1);
        wait_hi(1'b0, 3000);
        chk({31'h0, (n >= 900 && n <= 1300)}, 32'h1);
        chk({31'h0, rst_pulse}, 32'h0);
        @(posedge clk);
        rchk(A_CTL, 8'hc0);
        idle(1);
        gie <= 1'b0;
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        vec <= 1'b1;
        @(posedge clk);
        vec <= 1'b0;
        @(posedge clk);
        rchk(A_CTL, 8'h40);
        gie <= 1'b1;
        wr(A_CTL, 8'h48);
        idle(1);
        wait_hi(1'b0, 3000);
        @(posedge clk);
        rchk(A_CTL, 8'h88);
        wr(A_CTL, 8'h88);
        rchk(A_CTL, 8'h08);
        idle(1);
        p0 = pulses;
        for (int i = 0; i < 6; i++) begin
            repeat (600) @(posedge clk);
            kick <= 1'b1;
            @(posedge clk);
            kick <= 1'b0;
        end
        chk(32'(pulses - p0), 32'h0);
        wait_hi(1'b1, 3000);
        @(negedge clk);
        chk({31'h0, rst_pulse}, 32'h0);
        @(posedge clk);
        rchk(A_CAUSE, 8'h08);
        wr(A_CTL, 8'h18);
        wr(A_CTL, 8'h00);
        idle(5);
        rchk(A_CTL, 8'h08);
        wr(A_CAUSE, 8'h00);
        wr(A_CTL, 8'h18);
        wr(A_CTL, 8'h00);
        idle(5);
        rchk(A_CTL, 8'h00);
        idle(1);
        bor_ev <= 1'b1;
        @(posedge clk);
        bor_ev <= 1'b0;
        fuse <= 1'b1;
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rchk(A_CAUSE, 8'h04);
        rchk(A_CTL, 8'h08);
        wr(A_CTL, 8'h0b);
        rchk(A_CTL, 8'h08);
        wr(A_CTL, 8'h18);
        wr(A_CTL, 8'h00);
        idle(5);
        rchk(A_CTL, 8'h08);
        wr(A_CTL, 8'h18);
        wr(A_CTL, 8'h0b);
        idle(5);
        rchk(A_CTL, 8'h0b);
        idle(1);
        // Code 3 is eight times the shortest period, counted from release
        wait_hi(1'b1, 12000);
        chk({31'h0, (n >= 9500 && n <= 10100)}, 32'h1);
        @(posedge clk);
        rchk(A_CAUSE, 8'h0c);
        idle(1);
        end_sim();
    end

endmodule

`default_nettype wire
